// ### bench/pin_source.sv
/*
  External clock source on the timer pin, below one 48th of the core clock.
  Assumes the bench merges its level with the design's pin driver.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_source (
  // Clock and enable
  input  wire logic clk,
  input  wire logic en,
  // Pin level
  output var logic  pin
);
  int unsigned cnt;
  initial pin = 1'b0;
  initial cnt = 0;
  // Period of 60 core clocks, high half then low half
  always @(posedge clk) begin
    cnt <= (!en || cnt == 59) ? 0 : cnt + 1;
    pin <= en && cnt < 30;
  end
endmodule
`default_nettype wire

// ### bench/prescaled_down_timer_props.sv
/*
  Concurrent checks on the ports of the prescaled down timer.
  Assumes one clock domain and a master that keeps Avalon-MM rules.
*/
`timescale 1ns/1ps
`default_nettype none
module prescaled_down_timer_props
  import timer_pkg::*;
(
  // Clock and reset
  input wire logic              clk,
  input wire logic              rstn,
  input wire logic              clk_en,
  // Avalon-MM slave
  input wire logic [addr_w-1:0] address,
  input wire logic              read,
  input wire logic              write,
  input wire logic [31:0]       writedata,
  input wire logic [3:0]        byteenable,
  input wire logic [31:0]       readdata,
  input wire logic              waitrequest,
  input wire logic [1:0]        response,
  // Timer pin and interrupt
  input wire logic              timer_pin_in,
  input wire logic              timer_pin_out,
  input wire logic              timer_pin_oe_n,
  input wire logic              irq
);
  logic mapped;
  assign mapped = (address == ctrl_addr) || (address == presc_addr) ||
                  (address == count_addr) || (address == irq_status_addr) ||
                  (address == irq_mask_addr);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_req_wait; (read || write) && waitrequest; endsequence
  sequence s_rd_ack; read && !waitrequest; endsequence
  sequence s_ctrl_wr;
    write && !waitrequest && address == ctrl_addr;
  endsequence
  a_wait_one_state: assert property (s_req_wait |=> !waitrequest)
    else $error("ack not one cycle after take");
  a_idle_no_wait: assert property (!(read || write) |-> !waitrequest)
    else $error("waitrequest while idle");
  a_unmapped_err: assert property ((s_rd_ack and !mapped) |->
    response == 2'h2 && readdata == 32'h0) else $error("unmapped read");
  a_mapped_okay: assert property ((read || write) && !waitrequest && mapped
    |-> response == 2'h0) else $error("mapped access refused");
  a_ctrl_bit6_zero: assert property (
    (s_rd_ack and (address == ctrl_addr)) |->
    readdata[31:8] == 24'h0 && !readdata[6]) else $error("ctrl spare bits");
  a_presc_width: assert property (
    (s_rd_ack and (address == presc_addr)) |->
    readdata[31:7] == 25'h0) else $error("prescaler wider than 7 bits");
  a_dir_sets_oe: assert property ((s_ctrl_wr and byteenable[0]) |=>
    timer_pin_oe_n == !$past(writedata[dir_bit])) else $error("pin direction");
  a_latch_high_in: assert property (timer_pin_oe_n &&
    $past(timer_pin_oe_n) |-> timer_pin_out) else $error("latch low in input");
  a_data_stands: assert property (!(read || write) |=>
    $stable(readdata) && $stable(response)) else $error("read data moved");
endmodule
`default_nettype wire

// ### bench/prescaled_down_timer_tb.sv
/*
  Self-checking bench for the prescaled down timer over Avalon-MM.
  Assumes the pin source model and the checker bound below.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fails++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module prescaled_down_timer_tb;
  import timer_pkg::*;
  logic              clk, rstn, read, write, src_en, pin_src, pin_wire, run_en;
  logic [addr_w-1:0] address;
  logic [31:0]       writedata, readdata;
  logic [3:0]        byteenable;
  logic              waitrequest, pin_out, pin_oe_n, irq;
  logic [1:0]        response, rr;
  logic [7:0]        rq, cv, rz;
  int                fails, n_checks, cyc;
  assign pin_wire = (pin_oe_n === 1'b0) ? pin_out : pin_src;
  prescaled_down_timer u_prescaled_down_timer (.clk(clk), .rstn(rstn),
    .clk_en(run_en), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .response(response), .timer_pin_in(pin_wire),
    .timer_pin_out(pin_out), .timer_pin_oe_n(pin_oe_n), .irq(irq));
  pin_source u_pin_source (.clk(clk), .en(src_en), .pin(pin_src));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic acc(input logic we, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    address <= a;
    writedata <= {24'h0, d};
    read <= !we;
    write <= we;
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    rq = readdata[7:0];
    rr = response;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    `CHK(rq, e)
  endtask
  task automatic wait_irq(input int mx);
    cyc = 0;
    while (irq !== 1'b1 && cyc < mx) begin
      @(negedge clk);
      cyc++;
    end
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #300us;
    fails++;
    stop_test;
  end
  initial begin
    rstn = 1'b0; read = 1'b0; write = 1'b0; address = '0;
    writedata = '0; byteenable = 4'hf; src_en = 1'b0;
    run_en = 1'b1;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK({pin_out, pin_oe_n}, 2'b11)
    rd_chk(ctrl_addr, 8'h00);
    rd_chk(presc_addr, 8'h7f);
    rd_chk(count_addr, 8'hff);
    acc(1'b0, 12'h100, 8'h00);
    `CHK(rr, 2'h2)
    acc(1'b1, ctrl_addr, 8'h08);
    acc(1'b1, presc_addr, 8'h2a);
    rd_chk(presc_addr, 8'h2a);
    acc(1'b1, count_addr, 8'h5a);
    rd_chk(count_addr, 8'h5a);
    acc(1'b1, count_addr, 8'h00);
    rd_chk(ctrl_addr, 8'h88);
    rd_chk(ctrl_addr, 8'h08);
    acc(1'b1, irq_mask_addr, 8'h01);
    `CHK(irq, 1'b1)
    acc(1'b1, irq_mask_addr, 8'h00);
    `CHK(irq, 1'b0)
    acc(1'b1, irq_mask_addr, 8'h01);
    acc(1'b1, irq_status_addr, 8'h01);
    `CHK(irq, 1'b0)
    acc(1'b1, ctrl_addr, 8'hc8);
    rd_chk(ctrl_addr, 8'h88);
    `CHK(irq, 1'b1)
    acc(1'b1, ctrl_addr, 8'h88);
    rd_chk(ctrl_addr, 8'h88);
    for (int n = 0; n < 8; n++) begin
      cv = {2'b00, 1'b1, 1'(n), 1'b0, 3'(n)};
      acc(1'b1, ctrl_addr, cv);
      acc(1'b1, count_addr, 8'h01);
      repeat (60) @(posedge clk);
      rd_chk(presc_addr, 8'h7f);
      rd_chk(count_addr, 8'h01);
      acc(1'b0, ctrl_addr, 8'h00);
      acc(1'b1, irq_status_addr, 8'h01);
      acc(1'b1, ctrl_addr, cv | 8'h08);
      wait_irq(48 * (2 ** n) + 20);
      `CHK(cyc >= 48 * ((2 ** n) - 1) - 2 && cyc <= 48 * (2 ** n) + 8, 1'b1)
      repeat (3) @(negedge clk);
      `CHK({pin_oe_n, pin_out}, {1'b0, cv[4]})
      rd_chk(ctrl_addr, cv | 8'h88);
    end
    acc(1'b1, ctrl_addr, 8'h28);
    acc(1'b0, count_addr, 8'h00);
    rz = rq;
    run_en <= 1'b0;
    repeat (200) @(posedge clk);
    run_en <= 1'b1;
    acc(1'b0, count_addr, 8'h00);
    `CHK(8'(rz - rq) <= 8'h01, 1'b1)
    acc(1'b1, ctrl_addr, 8'h08);
    acc(1'b1, count_addr, 8'h03);
    acc(1'b0, ctrl_addr, 8'h00);
    acc(1'b1, irq_status_addr, 8'h01);
    src_en <= 1'b1;
    wait_irq(260);
    `CHK(cyc >= 110 && cyc <= 200, 1'b1)
    `CHK({pin_oe_n, pin_out}, 2'b11)
    rd_chk(irq_status_addr, 8'h03);
    src_en <= 1'b0;
    stop_test;
  end
endmodule
bind prescaled_down_timer prescaled_down_timer_props u_prescaled_down_timer_props (
  .clk(clk), .rstn(rstn), .clk_en(clk_en), .address(address), .read(read),
  .write(write), .writedata(writedata), .byteenable(byteenable),
  .readdata(readdata), .waitrequest(waitrequest), .response(response),
  .timer_pin_in(timer_pin_in), .timer_pin_out(timer_pin_out),
  .timer_pin_oe_n(timer_pin_oe_n), .irq(irq));
`default_nettype wire

// ### hdl/pin_edge_sync.sv
/*
  Two-flop synchroniser with rising-edge detector for the timer pin.
  Assumes an asynchronous input and a clock enable on the core clock.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_edge_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic clk_en,
  // Pin and edge
  input  wire logic pin_in,
  output logic      rise
);
  logic meta_ff;
  logic sync_ff;
  logic last_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      last_ff <= 1'b0;
    end else if (clk_en) begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  assign rise = clk_en & sync_ff & ~last_ff;
endmodule
`default_nettype wire

// ### hdl/prescaled_down_timer.sv
/*
  Prescaled 8-bit down timer with a 7-bit prescaler, a control/status
  register, pin direction and output latch, behind an Avalon-MM slave.
  Assumes a single core clock and a pin input from outside its domain.
*/
`timescale 1ns/1ps
`default_nettype none
module prescaled_down_timer (
  // Clock, reset, enable
  input  wire logic                         clk,
  input  wire logic                         rstn,
  input  wire logic                         clk_en,
  // Avalon-MM slave
  input  wire logic [timer_pkg::addr_w-1:0] address,
  input  wire logic                         read,
  input  wire logic                         write,
  input  wire logic [31:0]                  writedata,
  input  wire logic [3:0]                   byteenable,
  output logic [31:0]                       readdata,
  output logic                              waitrequest,
  output logic [1:0]                        response,
  // Timer pin
  input  wire logic                         timer_pin_in,
  output logic                              timer_pin_out,
  output logic                              timer_pin_oe_n,
  // Interrupt
  output logic                              irq
);
  import timer_pkg::*;

  // Reset release
  logic              rst_meta_ff;
  logic              rst_n;

  // Registers
  logic [7:0]        ctrl_ff;
  logic              zero_flag_ff;
  logic [6:0]        presc_ff;
  logic [7:0]        count_ff;
  logic              latch_ff;
  logic              zero_last_ff;
  logic [irq_w-1:0]  irq_status_ff;
  logic [irq_w-1:0]  irq_mask_ff;

  // Bus answer
  logic              ack_ff;
  logic [31:0]       readdata_ff;
  logic [1:0]        response_ff;
  logic [31:0]       nxt_readdata;
  logic [1:0]        nxt_response;

  // Count path
  logic              pin_rise;
  logic              sync_pulse;
  logic              presc_clk;
  logic              running;
  logic [6:0]        nxt_presc;
  logic [6:0]        bit_rise;
  logic [div_w-1:0]  divide_code;
  logic              tap_rise;
  logic              count_dec;
  logic              hit_zero;

  // Bus decode
  logic              acc;
  logic              wr_en;
  logic              rd_en;
  logic              sel_ctrl;
  logic              sel_presc;
  logic              sel_count;
  logic              sel_stat;
  logic              sel_mask;
  logic              wr_ctrl;
  logic              wr_presc;
  logic              wr_count;
  logic              wr_stat;
  logic              wr_mask;
  logic              rd_ctrl;

  // Flag and interrupt events
  logic              set_zero;
  logic              zero_rise;
  logic [irq_w-1:0]  irq_events;

  // Reset release
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_ff <= 1'b0;
      rst_n       <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n       <= rst_meta_ff;
    end
  end

  function automatic logic hit(input logic [addr_w-1:0] a,
                               input logic [addr_w-1:0] r);
    hit = (a == r);
  endfunction

  // Prescaler clock sources
  pin_edge_sync u_pin_sync (
    .clk    (clk),
    .rst_n  (rst_n),
    .clk_en (clk_en),
    .pin_in (timer_pin_in),
    .rise   (pin_rise)
  );

  sync_pulse_gen u_sync (
    .clk    (clk),
    .rst_n  (rst_n),
    .clk_en (clk_en),
    .pulse  (sync_pulse)
  );

  assign presc_clk = ctrl_ff[dir_bit] ? sync_pulse : pin_rise;
  assign running   = ctrl_ff[hold_n_bit];

  // Prescaler tap: selected bit going high on a decrement
  assign nxt_presc   = presc_ff - presc_one;
  assign divide_code = ctrl_ff[div_lsb +: div_w];

  for (genvar g = 0; g < presc_w; g++) begin : g_tap
    assign bit_rise[g] = nxt_presc[g] & ~presc_ff[g];
  end

  always_comb begin
    if (divide_code == div_by_one) begin
      tap_rise = 1'b1;
    end else begin
      tap_rise = bit_rise[divide_code - div_step];
    end
  end

  assign count_dec = running & presc_clk & tap_rise;
  assign hit_zero  = count_dec & (count_ff == count_one);

  // Bus decode
  assign acc      = clk_en & rst_n & (read | write) & ~ack_ff;
  assign wr_en    = acc & write & byteenable[0];
  assign rd_en    = acc & read;
  assign sel_ctrl  = hit(address, ctrl_addr);
  assign sel_presc = hit(address, presc_addr);
  assign sel_count = hit(address, count_addr);
  assign sel_stat  = hit(address, irq_status_addr);
  assign sel_mask  = hit(address, irq_mask_addr);
  assign wr_ctrl   = wr_en & sel_ctrl;
  assign wr_presc  = wr_en & sel_presc;
  assign wr_count  = wr_en & sel_count;
  assign wr_stat   = wr_en & sel_stat;
  assign wr_mask   = wr_en & sel_mask;
  assign rd_ctrl   = rd_en & sel_ctrl;

  // Prescaler
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      presc_ff <= presc_rst;
    end else if (clk_en) begin
      if (wr_presc) begin
        presc_ff <= writedata[6:0];
      end else if (!running) begin
        presc_ff <= presc_rst;
      end else if (presc_clk) begin
        presc_ff <= nxt_presc;
      end
    end
  end

  // Down counter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_ff <= count_rst;
    end else if (clk_en) begin
      if (wr_count) begin
        count_ff <= writedata[7:0];
      end else if (count_dec) begin
        count_ff <= count_ff - count_one;
      end
    end
  end

  // Control bits
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= ctrl_rst;
    end else if (clk_en && wr_ctrl) begin
      ctrl_ff <= writedata[7:0] & ctrl_wmask;
    end
  end

  // Zero flag: software write of counter/prescaler masks the timeout
  assign set_zero = (hit_zero & ~wr_presc & ~wr_count)
                  | (wr_count & (writedata[7:0] == count_zero))
                  | (wr_ctrl & writedata[zero_bit]);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      zero_flag_ff <= 1'b0;
    end else if (clk_en) begin
      if (set_zero) begin
        zero_flag_ff <= 1'b1;
      end else if (rd_ctrl && zero_flag_ff) begin
        zero_flag_ff <= 1'b0;
      end
    end
  end

  // Output latch
  assign zero_rise = zero_flag_ff & ~zero_last_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      zero_last_ff <= 1'b0;
    end else if (clk_en) begin
      zero_last_ff <= zero_flag_ff;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_ff <= 1'b1;
    end else if (clk_en) begin
      if (!ctrl_ff[dir_bit]) begin
        latch_ff <= 1'b1;
      end else if (zero_rise) begin
        latch_ff <= ctrl_ff[dout_bit];
      end
    end
  end

  assign timer_pin_out  = latch_ff;
  assign timer_pin_oe_n = ~ctrl_ff[dir_bit];

  // Interrupt status and mask
  assign irq_events = {pin_rise, zero_rise};
  // Write one to clear; a new event wins over the clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status_ff <= '0;
    end else if (clk_en) begin
      if (wr_stat) begin
        irq_status_ff <= irq_events |
                         (irq_status_ff & ~writedata[irq_w-1:0]);
      end else begin
        irq_status_ff <= irq_events | irq_status_ff;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask_ff <= '0;
    end else if (clk_en && wr_mask) begin
      irq_mask_ff <= writedata[irq_w-1:0];
    end
  end
  assign irq = |(irq_status_ff & irq_mask_ff);

  // Read mux; unmapped addresses answer with an error
  always_comb begin
    nxt_readdata = '0;
    nxt_response = resp_okay;
    unique case (1'b1)
      sel_ctrl:  nxt_readdata[7:0] = {zero_flag_ff, ctrl_ff[6:0]};
      sel_presc: nxt_readdata[6:0] = presc_ff;
      sel_count: nxt_readdata[7:0] = count_ff;
      sel_stat:  nxt_readdata[irq_w-1:0] = irq_status_ff;
      sel_mask:  nxt_readdata[irq_w-1:0] = irq_mask_ff;
      default:   nxt_response = resp_slverr;
    endcase
  end

  // Bus answer, one wait state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_ff <= 1'b0;
    end else if (clk_en) begin
      ack_ff <= acc;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      readdata_ff <= '0;
      response_ff <= resp_okay;
    end else if (clk_en && acc) begin
      readdata_ff <= nxt_readdata;
      response_ff <= nxt_response;
    end
  end

  assign waitrequest = (read | write) & ~ack_ff;
  assign readdata    = readdata_ff;
  assign response    = response_ff;
endmodule
`default_nettype wire

// ### hdl/sync_pulse_gen.sv
/*
  Internal sync pulse: one cycle high every 48 enabled core clocks.
  Assumes the core clock stands for the oscillator.
*/
`timescale 1ns/1ps
`default_nettype none
module sync_pulse_gen (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic clk_en,
  // Pulse
  output logic      pulse
);
  import timer_pkg::*;

  logic [5:0] cnt_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 6'h00;
    end else if (clk_en) begin
      cnt_ff <= (cnt_ff == sync_last) ? 6'h00 : cnt_ff + 6'h01;
    end
  end

  assign pulse = clk_en & (cnt_ff == sync_last);
endmodule
`default_nettype wire

// ### hdl/timer_pkg.sv
/*
  Constants shared by the prescaled down timer: register map, field
  positions, reset values and divider figures.
  Assumes an 8-bit register space reached over a 32-bit Avalon-MM slave.
*/
package timer_pkg;
  // Register byte addresses (index times four)
  localparam logic [9:0] ctrl_idx       = 10'h009;
  localparam logic [9:0] presc_idx      = 10'h0fd;
  localparam logic [9:0] count_idx      = 10'h0fe;
  localparam logic [9:0] irq_status_idx = 10'h0f0;
  localparam logic [9:0] irq_mask_idx   = 10'h0f1;
  localparam int         addr_w         = 12;
  localparam logic [11:0] ctrl_addr       = {ctrl_idx, 2'h0};
  localparam logic [11:0] presc_addr      = {presc_idx, 2'h0};
  localparam logic [11:0] count_addr      = {count_idx, 2'h0};
  localparam logic [11:0] irq_status_addr = {irq_status_idx, 2'h0};
  localparam logic [11:0] irq_mask_addr   = {irq_mask_idx, 2'h0};
  // Control/status fields
  localparam int zero_bit    = 7;
  localparam int dir_bit     = 5;
  localparam int dout_bit    = 4;
  localparam int hold_n_bit  = 3;
  localparam int div_lsb     = 0;
  localparam int div_w       = 3;
  localparam logic [7:0] ctrl_wmask = 8'h3f;
  // Reset values and counter constants
  localparam logic [7:0] ctrl_rst  = 8'h00;
  localparam logic [6:0] presc_rst = 7'h7f;
  localparam logic [7:0] count_rst = 8'hff;
  localparam logic [7:0] count_one = 8'h01;
  localparam logic [7:0] count_zero = 8'h00;
  // Prescaler width and divider tap coding
  localparam int         presc_w    = 7;
  localparam logic [6:0] presc_one  = 7'h01;
  localparam logic [2:0] div_by_one = 3'h0;
  localparam logic [2:0] div_step   = 3'h1;
  // Internal sync pulse: oscillator divided by 48
  localparam int         sync_div = 48;
  localparam logic [5:0] sync_last = 6'(sync_div - 1);
  // Interrupt status bits
  localparam int irq_w        = 2;
  localparam int irq_zero_bit = 0;
  localparam int irq_pin_bit  = 1;
  // Avalon response codes
  localparam logic [1:0] resp_okay   = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
endpackage
